// ---- rtl/accel_sample_register_bank.sv ----
`timescale 1ns/1ps
module accel_sample_register_bank (
    input  wire logic              i_mclk,         // system clock, 200 MHz
    input  wire logic              i_reset_n,      // async reset, active low
    input  wire logic              i_scl,          // bus clock pin
    input  wire logic              i_sda,          // bus data pin level
    output logic                   o_sda_out,      // data drive value, always low
    output logic                   o_sda_oe,       // data drive enable
    input  wire logic              i_enable,       // enable pin
    input  wire logic              i_sample_valid, // new sample strobe
    input  wire accel_pkg::sample_t i_sample,      // new x, y, z sample
    output logic [7:0]             o_status        // live status byte
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // status byte from flags; upper nibble always zero
    function automatic logic [7:0] status_byte(input accel_pkg::state_t s);
        status_byte = {4'h0, s.all_ready, s.ready};   // [RQ6] [RQ9]
    endfunction

    // register contents as seen by a read at ptr
    function automatic logic [7:0] read_reg(input logic [7:0] ptr,
                                            input accel_pkg::state_t s);
        case (ptr)                                     // [RQ3]
            accel_pkg::REG_STATUS: read_reg = status_byte(s);
            accel_pkg::REG_X_HIGH:
                read_reg = s.smp.x[accel_pkg::SAMPLE_W-1:accel_pkg::HIGH_LSB]; // [RQ10]
            accel_pkg::REG_X_LOW:  read_reg = {s.lo_hold[0], 2'h0};  // [RQ13]
            accel_pkg::REG_Y_HIGH:
                read_reg = s.smp.y[accel_pkg::SAMPLE_W-1:accel_pkg::HIGH_LSB];
            accel_pkg::REG_Y_LOW:  read_reg = {s.lo_hold[1], 2'h0};
            accel_pkg::REG_Z_HIGH:
                read_reg = s.smp.z[accel_pkg::SAMPLE_W-1:accel_pkg::HIGH_LSB];
            accel_pkg::REG_Z_LOW:  read_reg = {s.lo_hold[2], 2'h0};
            default:               read_reg = 8'h00;  // [RQ21]
        endcase
    endfunction

    // auto-increment with wrap from the last data byte to status
    function automatic logic [7:0] next_ptr(input logic [7:0] ptr);
        if (ptr == accel_pkg::REG_Z_LOW) begin
            next_ptr = accel_pkg::REG_STATUS;          // [RQ4]
        end else begin
            next_ptr = ptr + 8'h01;                    // [RQ1]
        end
    endfunction

    // ----------------------------------------------------------------
    // state and pin events
    // ----------------------------------------------------------------
    accel_pkg::state_t st_ff;
    accel_pkg::state_t nxt_st;
    logic              scl_pin;
    logic              sda_pin;
    logic              en_pin;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic              load_byte;
    logic [7:0]        rd_byte;

    // edges are taken from the second and third stage only
    assign scl_pin   = st_ff.sync2[accel_pkg::PIN_SCL];
    assign sda_pin   = st_ff.sync2[accel_pkg::PIN_SDA];
    assign en_pin    = st_ff.sync2[accel_pkg::PIN_EN];
    assign scl_rise  = scl_pin & ~st_ff.last[accel_pkg::PIN_SCL];
    assign scl_fall  = ~scl_pin & st_ff.last[accel_pkg::PIN_SCL];
    assign start_det = scl_pin & st_ff.last[accel_pkg::PIN_SCL]
                     & ~sda_pin & st_ff.last[accel_pkg::PIN_SDA];
    assign stop_det  = scl_pin & st_ff.last[accel_pkg::PIN_SCL]
                     & sda_pin & ~st_ff.last[accel_pkg::PIN_SDA];
    assign rd_byte   = read_reg(st_ff.ptr, st_ff);

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // bus sequencer, read side effects, then sample and enable updates
    always_comb begin
        nxt_st       = st_ff;
        load_byte    = 1'b0;
        nxt_st.sync1 = {i_enable, i_sda, i_scl};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.last  = st_ff.sync2;

        case (st_ff.fsm)
            accel_pkg::ST_IDLE: begin
                nxt_st.oe = 1'b0;
            end
            accel_pkg::ST_ADDR: begin
                if (scl_rise) begin
                    nxt_st.shift = {st_ff.shift[6:0], sda_pin};
                    nxt_st.cnt   = st_ff.cnt + 4'h1;
                end else if (scl_fall && st_ff.cnt == accel_pkg::BITS_PER_BYTE) begin
                    nxt_st.cnt = 4'h0;
                    if (st_ff.shift[7:1] == accel_pkg::DEV_ADDR) begin   // [RQ18]
                        nxt_st.rw  = st_ff.shift[0];
                        nxt_st.oe  = 1'b1;
                        nxt_st.fsm = accel_pkg::ST_ADDR_ACK;
                    end else begin
                        nxt_st.fsm = accel_pkg::ST_IDLE;
                    end
                end
            end
            accel_pkg::ST_ADDR_ACK: begin
                if (scl_fall) begin
                    if (st_ff.rw) begin
                        load_byte = 1'b1;                  // read starts at stored ptr [RQ19]
                    end else begin
                        nxt_st.oe       = 1'b0;
                        nxt_st.ptr_done = 1'b0;
                        nxt_st.fsm      = accel_pkg::ST_PTR;
                    end
                end
            end
            accel_pkg::ST_PTR: begin
                if (scl_rise) begin
                    nxt_st.shift = {st_ff.shift[6:0], sda_pin};
                    nxt_st.cnt   = st_ff.cnt + 4'h1;
                end else if (scl_fall && st_ff.cnt == accel_pkg::BITS_PER_BYTE) begin
                    nxt_st.cnt = 4'h0;
                    nxt_st.oe  = 1'b1;
                    nxt_st.fsm = accel_pkg::ST_PTR_ACK;
                    // only the first byte is a pointer; data bytes are acked and dropped
                    if (!st_ff.ptr_done) begin            // [RQ17] [RQ21]
                        nxt_st.ptr      = st_ff.shift;    // [RQ19]
                        nxt_st.ptr_done = 1'b1;
                    end
                end
            end
            accel_pkg::ST_PTR_ACK: begin
                if (scl_fall) begin
                    nxt_st.oe  = 1'b0;
                    nxt_st.fsm = accel_pkg::ST_PTR;
                end
            end
            accel_pkg::ST_TX: begin
                if (scl_fall) begin
                    if (st_ff.cnt == accel_pkg::LAST_TX_BIT) begin
                        nxt_st.oe  = 1'b0;                // release for master ack
                        nxt_st.cnt = 4'h0;
                        nxt_st.fsm = accel_pkg::ST_TX_ACK;
                    end else begin
                        nxt_st.shift = {st_ff.shift[6:0], 1'b0};
                        nxt_st.oe    = ~st_ff.shift[6];
                        nxt_st.cnt   = st_ff.cnt + 4'h1;
                    end
                end
            end
            accel_pkg::ST_TX_ACK: begin
                if (scl_rise) begin
                    nxt_st.acked = ~sda_pin;
                end else if (scl_fall) begin
                    if (st_ff.acked) begin
                        load_byte = 1'b1;                 // [RQ2]
                    end else begin
                        nxt_st.fsm = accel_pkg::ST_IDLE;  // nack: stop driving [RQ2]
                    end
                end
            end
            default: begin
                nxt_st.fsm = accel_pkg::ST_IDLE;
                nxt_st.oe  = 1'b0;
            end
        endcase

        // fetch a byte; a high-byte read freezes its low bits and clears its flag
        if (load_byte) begin
            nxt_st.shift = rd_byte;
            nxt_st.oe    = ~rd_byte[7];
            nxt_st.cnt   = 4'h0;
            nxt_st.fsm   = accel_pkg::ST_TX;
            nxt_st.ptr   = next_ptr(st_ff.ptr);              // [RQ1]
            case (st_ff.ptr)
                accel_pkg::REG_X_HIGH: begin
                    nxt_st.ready[0]   = 1'b0;                // [RQ8]
                    nxt_st.hi_read[0] = 1'b1;
                    nxt_st.lo_hold[0] = st_ff.smp.x[5:0];    // [RQ13] [RQ12]
                end
                accel_pkg::REG_Y_HIGH: begin
                    nxt_st.ready[1]   = 1'b0;
                    nxt_st.hi_read[1] = 1'b1;
                    nxt_st.lo_hold[1] = st_ff.smp.y[5:0];
                end
                accel_pkg::REG_Z_HIGH: begin
                    nxt_st.ready[2]   = 1'b0;
                    nxt_st.hi_read[2] = 1'b1;
                    nxt_st.lo_hold[2] = st_ff.smp.z[5:0];
                end
                default: begin
                    nxt_st.hi_read = st_ff.hi_read;
                end
            endcase
            if (&nxt_st.hi_read) begin
                nxt_st.all_ready = 1'b0;                     // [RQ7]
                nxt_st.hi_read   = 3'h0;
            end
        end

        // a start, even repeated, keeps the pointer for the read that follows
        if (start_det) begin
            nxt_st.fsm = accel_pkg::ST_ADDR;
            nxt_st.cnt = 4'h0;
            nxt_st.oe  = 1'b0;
        end
        if (stop_det) begin
            nxt_st.fsm      = accel_pkg::ST_IDLE;
            nxt_st.oe       = 1'b0;
            nxt_st.ptr      = accel_pkg::REG_STATUS;      // [RQ5]
            nxt_st.ptr_done = 1'b0;
        end

        // new sample: placed after the clears so a same-cycle set wins
        if (i_sample_valid) begin
            nxt_st.smp       = i_sample;                  // [RQ11] [RQ16]
            nxt_st.ready     = 3'h7;                      // [RQ8]
            nxt_st.all_ready = 1'b1;                      // [RQ7]
            nxt_st.hi_read   = 3'h0;
        end

        // enable low wipes contents; acquisition needs enable anyway
        if (!en_pin) begin
            nxt_st.smp       = '0;                        // [RQ15]
            nxt_st.ready     = 3'h0;
            nxt_st.all_ready = 1'b0;
            nxt_st.hi_read   = 3'h0;
            nxt_st.lo_hold   = '0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff <= accel_pkg::STATE_RESET;              // [RQ9]
        end else begin
            st_ff <= nxt_st;
        end
    end

    // open-drain: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe  = st_ff.oe;
    assign o_status  = status_byte(st_ff);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    AST_PTR_INC: assert property ( // [RQ1]
        load_byte && st_ff.ptr < accel_pkg::REG_Z_LOW
        |=> st_ff.ptr == $past(st_ff.ptr) + 8'h01)
        else $error("pointer did not advance after a byte");

    AST_PTR_WRAP: assert property ( // [RQ4]
        load_byte && st_ff.ptr == accel_pkg::REG_Z_LOW
        |=> st_ff.ptr == accel_pkg::REG_STATUS)
        else $error("pointer did not wrap to status");

    AST_STOP_PTR: assert property ( // [RQ5]
        stop_det |=> st_ff.ptr == accel_pkg::REG_STATUS
                     && st_ff.fsm == accel_pkg::ST_IDLE && !o_sda_oe)
        else $error("stop did not discard pointer");

    AST_NACK_END: assert property ( // [RQ2]
        st_ff.fsm == accel_pkg::ST_TX_ACK && scl_fall && !st_ff.acked
        |=> !o_sda_oe [*3])
        else $error("data still driven after nack");

    AST_STATUS_TOP: assert property ( // [RQ6]
        load_byte && st_ff.ptr == accel_pkg::REG_STATUS
        |=> st_ff.shift[7:4] == 4'h0 && st_ff.shift[3:0] == $past(o_status[3:0]))
        else $error("status byte malformed");

    AST_X_CLEAR: assert property ( // [RQ8]
        load_byte && st_ff.ptr == accel_pkg::REG_X_HIGH && !i_sample_valid
        |=> !o_status[0])
        else $error("x flag not cleared by high read");

    AST_SAMPLE_SET: assert property ( // [RQ9]
        i_sample_valid && en_pin |=> o_status[3:0] == 4'hF)
        else $error("flags not set by new sample");

    AST_ALL_FALL: assert property ( // [RQ7]
        st_ff.all_ready && !nxt_st.all_ready && en_pin
        |-> load_byte && st_ff.hi_read != 3'h0)
        else $error("all-axes flag cleared without high reads");

    AST_EN_CLEAR: assert property ( // [RQ15]
        !en_pin |=> o_status == accel_pkg::STATUS_RESET && st_ff.smp == '0)
        else $error("enable low did not clear contents");

    AST_LOW_HOLD: assert property ( // [RQ13]
        load_byte && st_ff.ptr == accel_pkg::REG_X_LOW
        |=> st_ff.shift == {$past(st_ff.lo_hold[0]), 2'h0})
        else $error("low byte not from held sample");

    AST_ADDR_ACK: assert property ( // [RQ18]
        st_ff.fsm == accel_pkg::ST_ADDR && scl_fall && !start_det
        && st_ff.cnt == accel_pkg::BITS_PER_BYTE
        && st_ff.shift[7:1] == accel_pkg::DEV_ADDR |=> o_sda_oe)
        else $error("own address not acknowledged");

    AST_RO: assert property ( // [RQ17]
        st_ff.fsm == accel_pkg::ST_PTR && st_ff.ptr_done && !i_sample_valid && en_pin
        |=> $stable(st_ff.smp))
        else $error("bus write changed sample data");

    AST_Y_CLEAR: assert property ( // [RQ8]
        load_byte && st_ff.ptr == accel_pkg::REG_Y_HIGH && !i_sample_valid
        |=> !o_status[1])
        else $error("y flag not cleared by high read");

    AST_Z_CLEAR: assert property ( // [RQ8]
        load_byte && st_ff.ptr == accel_pkg::REG_Z_HIGH && !i_sample_valid
        |=> !o_status[2])
        else $error("z flag not cleared by high read");

    AST_HIGH_BYTE: assert property ( // [RQ10]
        load_byte && st_ff.ptr == accel_pkg::REG_Y_HIGH
        |=> st_ff.shift == $past(st_ff.smp.y[accel_pkg::SAMPLE_W-1:accel_pkg::HIGH_LSB]))
        else $error("high byte does not carry the upper sample bits");

    AST_UNMAPPED: assert property ( // [RQ21]
        load_byte && st_ff.ptr > accel_pkg::REG_Z_LOW
        |=> st_ff.shift == 8'h00)
        else $error("unmapped register did not read zero");

    AST_WRITE_ACK: assert property ( // [RQ21]
        st_ff.fsm == accel_pkg::ST_PTR && scl_fall
        && st_ff.cnt == accel_pkg::BITS_PER_BYTE
        |=> o_sda_oe && st_ff.fsm == accel_pkg::ST_PTR_ACK)
        else $error("written byte not acknowledged");

    COV_WRAP: cover property (load_byte && st_ff.ptr == accel_pkg::REG_Z_LOW);
    COV_NACK: cover property (st_ff.fsm == accel_pkg::ST_TX_ACK && scl_fall && !st_ff.acked);
    COV_RSTART: cover property (start_det && st_ff.fsm == accel_pkg::ST_PTR);
    COV_ALL_CLR: cover property ($fell(st_ff.all_ready) && en_pin);
    COV_UNMAPPED: cover property (load_byte && st_ff.ptr > accel_pkg::REG_Z_LOW);

endmodule

// ---- rtl/accel_pkg.sv ----
// Operation
// [RQ1] burst read advances pointer after each byte
// [RQ2] master ack continues burst, nack ends it
// [RQ3] status at 0x00, samples at 0x01-0x06
// [RQ4] pointer wraps from 0x06 to 0x00
// [RQ5] stop condition discards the stored pointer
// [RQ6] status bits 7-4 zero, then ready flags
// [RQ7] all-axes flag clears after all highs read
// [RQ8] axis flag set on sample, cleared on high
// [RQ9] flags read 1 when pending, reset zero
// [RQ10] high byte bits 13-6, low bits 5-0
// [RQ11] samples are 14-bit two's complement values
// [RQ12] low byte read only after its high
// [RQ13] high read holds matching low byte
// [RQ14] host reads data after all-axes ready
// [RQ15] enable low clears all register contents
// [RQ16] contents retained while enable stays high
// [RQ17] all registers read-only, fed by acquisition
// [RQ18] slave answers to address 0x55
// [RQ19] pointer written, then repeated start read
// [RQ20] host keeps enable high for valid data
// [RQ21] unmapped reads give zero, writes ignored
package accel_pkg;

    // ----------------------------------------------------------------
    // bus address and register map
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR     = 7'h55;
    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_X_HIGH   = 8'h01;
    localparam logic [7:0] REG_X_LOW    = 8'h02;
    localparam logic [7:0] REG_Y_HIGH   = 8'h03;
    localparam logic [7:0] REG_Y_LOW    = 8'h04;
    localparam logic [7:0] REG_Z_HIGH   = 8'h05;
    localparam logic [7:0] REG_Z_LOW    = 8'h06;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // field layout and counts
    // ----------------------------------------------------------------
    localparam int         SAMPLE_W      = 14;
    localparam int         HIGH_LSB      = 6;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT   = 4'h7;
    localparam int         PIN_SCL       = 0;
    localparam int         PIN_SDA       = 1;
    localparam int         PIN_EN        = 2;
    localparam logic [2:0] PINS_IDLE     = 3'h3;   // bus lines high, enable low

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_PTR      = 7'h08,
        ST_PTR_ACK  = 7'h10,
        ST_TX       = 7'h20,
        ST_TX_ACK   = 7'h40
    } fsm_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] x;
        logic [SAMPLE_W-1:0] y;
        logic [SAMPLE_W-1:0] z;
    } sample_t;

    typedef struct packed {
        logic [2:0]      sync1;
        logic [2:0]      sync2;
        logic [2:0]      last;
        fsm_t            fsm;
        logic [3:0]      cnt;
        logic [7:0]      shift;
        logic [7:0]      ptr;
        logic            rw;
        logic            ptr_done;
        logic            oe;
        logic            acked;
        sample_t         smp;
        logic [2:0]      ready;     // z, y, x
        logic            all_ready;
        logic [2:0]      hi_read;   // z, y, x high bytes read
        logic [2:0][5:0] lo_hold;   // z, y, x held low bits
    } state_t;

    localparam state_t STATE_RESET = '{
        sync1: PINS_IDLE, sync2: PINS_IDLE, last: PINS_IDLE,
        fsm: ST_IDLE, ptr: REG_STATUS, default: '0};

endpackage

// ---- tb/i2c_host_model.sv ----
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic i_sda,  // wired level of the data line
    output logic      o_scl,  // bus clock, idle high
    output logic      o_sda   // 0 pulls data low, 1 releases to the pull-up
);
    // ----------------------------------------------------------------
    // quarter-bit clock, free in phase from the system clock
    // ----------------------------------------------------------------
    logic       q_clk;
    logic [7:0] rd_q[$];  // bytes returned by the last read
    int         dev_nak;  // device bits seen high in its acknowledge slots

    // four quarters of 40 ns give a 160 ns bit; the offset keeps edges off the mclk grid
    initial begin
        q_clk = 1'b0;
        o_scl = 1'b1;
        o_sda = 1'b1;
        #13;
        forever #20 q_clk = ~q_clk;
    end

    // data only changes while the clock is low, a full quarter away from either edge
    task automatic bit_io(input logic b, output logic r);
        @(posedge q_clk) o_sda <= b;
        @(posedge q_clk) o_scl <= 1'b1;
        @(posedge q_clk) r = i_sda;
        @(posedge q_clk) o_scl <= 1'b0;
    endtask

    // eight bits msb first, then the acknowledge slot driven with tail
    task automatic byte_io(input logic [7:0] tx, input logic tail, output logic [7:0] rx,
                           output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], b);
            rx[i] = b;
        end
        bit_io(tail, ack);
    endtask

    // start and repeated start both end with the clock low
    task automatic start_cond();
        @(posedge q_clk) o_sda <= 1'b1;
        @(posedge q_clk) o_scl <= 1'b1;
        @(posedge q_clk) o_sda <= 1'b0;
        @(posedge q_clk) o_scl <= 1'b0;
    endtask

    // the clock stands high after a stop until the next frame
    task automatic stop_cond();
        @(posedge q_clk) o_sda <= 1'b0;
        @(posedge q_clk) o_scl <= 1'b1;
        @(posedge q_clk) o_sda <= 1'b1;
        @(posedge q_clk) o_sda <= 1'b1;
    endtask

    // one frame: optional pointer write and extra data, then an optional burst read
    task automatic xfer(input logic [6:0] dev, input logic set_ptr, input logic [7:0] ptr,
                        input int n_wr, input int n_rd);
        logic [7:0] rx;
        logic       ack;
        rd_q.delete();
        dev_nak = 0;
        start_cond();
        if (set_ptr) begin
            byte_io({dev, 1'b0}, 1'b1, rx, ack);
            dev_nak += ack;
            byte_io(ptr, 1'b1, rx, ack);
            dev_nak += ack;
            for (int k = 0; k < n_wr; k++) begin
                byte_io(8'hA5, 1'b1, rx, ack);
                dev_nak += ack;
            end
            if (n_rd > 0) start_cond();
        end
        if (n_rd > 0) begin
            byte_io({dev, 1'b1}, 1'b1, rx, ack);
            dev_nak += ack;
            for (int k = 0; k < n_rd; k++) begin
                byte_io(8'hFF, (k == n_rd - 1), rx, ack);
                rd_q.push_back(rx);
            end
        end
        stop_cond();
    endtask
endmodule

// ---- tb/accel_sample_register_bank_tb_top.sv ----
`timescale 1ns/1ps
module accel_sample_register_bank_tb_top;
    // ----------------------------------------------------------------
    // signals and constants
    // ----------------------------------------------------------------
    logic                mclk;
    logic                reset_n;
    logic                scl;
    logic                host_sda;
    logic                sda_line;
    logic                sda_out;
    logic                sda_oe;
    logic                enable;
    logic                smp_valid;
    accel_pkg::sample_t  smp;
    logic [7:0]          status;
    int                  bad_count;
    int                  compares;
    localparam accel_pkg::sample_t S1 = '{x: 14'h2ABC, y: 14'h1234, z: 14'h3FFF};
    localparam accel_pkg::sample_t S2 = '{x: 14'h0155, y: 14'h3A01, z: 14'h2000};

    // open-drain data line with a pull-up: low if either side pulls
    assign sda_line = host_sda & ~(sda_oe & ~sda_out);

    always #2.5 mclk = ~mclk;

    accel_sample_register_bank dut_u (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda_line),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_enable(enable),
        .i_sample_valid(smp_valid), .i_sample(smp), .o_status(status));

    i2c_host_model host_u (.i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));

    // ----------------------------------------------------------------
    // compare and helper tasks
    // ----------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the whole returned burst, length first
    task automatic chk_q(input logic [7:0] e[$]);
        chk_byte(8'(host_u.rd_q.size()), 8'(e.size()));
        foreach (e[k]) chk_byte(host_u.rd_q[k], e[k]);
    endtask

    function automatic logic [7:0] hi(input logic [13:0] v);
        return v[13:6];
    endfunction

    function automatic logic [7:0] lo(input logic [13:0] v);
        return {v[5:0], 2'h0};
    endfunction

    // one-cycle strobe, then let the flags land
    task automatic push(input accel_pkg::sample_t s);
        @(posedge mclk);
        smp       <= s;
        smp_valid <= 1'b1;
        @(posedge mclk);
        smp_valid <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_burst();
        push(S1);
        chk_byte(status, 8'h0F);
        host_u.xfer(7'h55, 1'b1, 8'h00, 0, 8);
        chk_byte(8'(host_u.dev_nak), 8'h00);
        chk_q('{8'h0F, hi(S1.x), lo(S1.x), hi(S1.y), lo(S1.y),
                hi(S1.z), lo(S1.z), 8'h00});
        chk_byte(status, 8'h00);
        chk_bit(sda_oe, 1'b0);
        $display("test burst done");
    endtask

    // high bytes read one at a time: the all-axes flag waits for the third
    task automatic test_flags();
        logic [7:0] ptrs[3] = '{8'h05, 8'h03, 8'h01};
        logic [7:0] stat[3] = '{8'h0B, 8'h09, 8'h00};
        logic [7:0] vals[3] = '{hi(S2.z), hi(S2.y), hi(S2.x)};
        push(S2);
        for (int k = 0; k < 3; k++) begin
            host_u.xfer(7'h55, 1'b1, ptrs[k], 0, 1);
            chk_q('{vals[k]});
            chk_byte(status, stat[k]);
        end
        $display("test flags done");
    endtask

    // a new sample lands between the high and low byte of one access
    task automatic test_hold();
        fork
            host_u.xfer(7'h55, 1'b1, 8'h01, 0, 2);
            begin
                repeat (1050) @(posedge mclk);
                push(S1);
            end
        join
        chk_q('{hi(S2.x), lo(S2.x)});
        chk_byte(status, 8'h0F);
        $display("test hold done");
    endtask

    task automatic test_bus();
        host_u.xfer(7'h54, 1'b1, 8'h00, 0, 0);
        chk_byte(8'(host_u.dev_nak), 8'h02);
        host_u.xfer(7'h55, 1'b1, 8'h03, 1, 0);
        chk_byte(8'(host_u.dev_nak), 8'h00);
        host_u.xfer(7'h55, 1'b0, 8'h00, 0, 2);
        chk_q('{8'h0F, hi(S1.x)});
        host_u.xfer(7'h55, 1'b1, 8'h07, 0, 2);
        chk_q('{8'h00, 8'h00});
        $display("test bus done");
    endtask

    task automatic test_enable();
        @(posedge mclk);
        enable <= 1'b0;
        repeat (6) @(posedge mclk);
        chk_byte(status, 8'h00);
        enable <= 1'b1;
        repeat (6) @(posedge mclk);
        host_u.xfer(7'h55, 1'b1, 8'h01, 0, 2);
        chk_q('{8'h00, 8'h00});
        $display("test enable done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        mclk      = 1'b0;
        reset_n   = 1'b0;
        enable    = 1'b1;
        smp_valid = 1'b0;
        smp       = '0;
        bad_count = 0;
        compares  = 0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        chk_byte(status, 8'h00);
        test_burst();
        test_flags();
        test_hold();
        test_bus();
        test_enable();
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        end_sim();
    end
endmodule
